// file: logic/uim_pkg.sv
// Constants shared by the interrupt mask and smart-card retry logic.
package uim_pkg;
    // Register byte offsets.
    localparam logic [7:0] UIM_OFS_MODE     = 8'h04;
    localparam logic [7:0] UIM_OFS_EN_SET   = 8'h08;
    localparam logic [7:0] UIM_OFS_DIS_CLR  = 8'h0c;
    localparam logic [7:0] UIM_OFS_MASK     = 8'h10;
    localparam logic [7:0] UIM_OFS_STATUS   = 8'h14;

    // Implemented event bits of enable, disable, mask and status.
    localparam logic [31:0] UIM_SRC_BITS    = 32'h000f_3fff;

    // Event bit positions.
    localparam int UIM_B_RX_CHAR_READY      = 0;
    localparam int UIM_B_TX_HOLDING_READY   = 1;
    localparam int UIM_B_RX_BREAK_SEEN      = 2;
    localparam int UIM_B_RX_TRANSFER_END    = 3;
    localparam int UIM_B_TX_TRANSFER_END    = 4;
    localparam int UIM_B_OVERRUN_ERROR      = 5;
    localparam int UIM_B_FRAMING_ERROR      = 6;
    localparam int UIM_B_PARITY_ERROR       = 7;
    localparam int UIM_B_RX_TIMEOUT         = 8;
    localparam int UIM_B_TX_FULLY_IDLE      = 9;
    localparam int UIM_B_RETRY_LIMIT        = 10;
    localparam int UIM_B_TX_BUFFER_DRAINED  = 11;
    localparam int UIM_B_RX_BUFFER_FULL     = 12;
    localparam int UIM_B_NEG_ACK            = 13;
    localparam int UIM_B_RING_IND_CHANGE    = 16;
    localparam int UIM_B_SET_READY_CHANGE   = 17;
    localparam int UIM_B_CARRIER_DET_CHANGE = 18;
    localparam int UIM_B_CLEAR_TO_SEND_CHG  = 19;

    // Mode register field positions.
    localparam int UIM_F_MODE_LSB           = 0;
    localparam int UIM_F_MODE_MSB           = 3;
    localparam int UIM_F_INHIBIT_NACK       = 20;
    localparam int UIM_F_LIMIT_NACK         = 21;
    localparam int UIM_F_MAX_ITER_LSB       = 24;
    localparam int UIM_F_MAX_ITER_MSB       = 26;
    localparam int UIM_F_FILTER             = 28;
    localparam logic [31:0] UIM_MODE_BITS   = 32'h1730_000f;
    localparam logic [31:0] UIM_MODE_RESET  = 32'h0000_0000;

    // Operating mode code of the character protocol T=0.
    localparam logic [3:0] UIM_MODE_ISO_T0  = 4'h4;

    // Sixteenth-bit sample rate as a divide of the 100 MHz clock.
    localparam int UIM_CLK_MHZ              = 100;
    localparam int UIM_SAMPLE_NS            = 160;
    localparam int UIM_SAMPLE_DIV           = (UIM_SAMPLE_NS * UIM_CLK_MHZ) / 1000;
    localparam logic [7:0] UIM_SAMPLE_LAST  = 8'(UIM_SAMPLE_DIV - 1);
endpackage : uim_pkg

// file: logic/uim_top.sv
// Interrupt mask, smart-card negative acknowledge policy and receive line filter.
//
// How it works
// R01 - With the inhibit setting high no negative acknowledge is ever driven, else they are made.
// R02 - Without limiting and with inhibit low, every received character with a parity error gets a negative acknowledge.
// R03 - With limiting, successive parity errors are counted and, with inhibit low, each counted one is acknowledged.
// R04 - Once the count is at the maximum, each further parity error gets no acknowledge and raises the retry-limit flag.
// R05 - The maximum count acts as the limit only in the T=0 smart-card mode.
// R06 - With the filter setting low the receive line reaches the receiver unfiltered.
// R07 - With the filter setting high the line is the 2-of-3 majority of sixteenth-bit samples.
// R08 - Ones written to the enable port set mask bits; zeros leave them alone.
// R09 - Ones written to the disable port clear mask bits; zeros leave them alone.
// R10 - The mask read shows a one for each enabled source and a zero for each disabled one.
// R11 - Bits 0 to 7 are rx ready, tx ready, break, rx end, tx end, overrun, framing, parity.
// R12 - Bits 8 to 13 are time-out, tx idle, retry limit, tx buffer empty, rx buffer full, nack.
// R13 - Bits 16 to 19 are ring indicator, set ready, carrier detect and clear to send changes.
// R14 - Bits 14, 15 and 20 to 31 are unused: writes do nothing and reads give zero.
// R15 - The interrupt is high while any source has both its status and mask bit set.
`timescale 1ns/1ps
module uim_top
    import uim_pkg::*;
(
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // Event pulses from the rest of the transceiver.
    input  wire logic        rx_char_ready,
    input  wire logic        tx_holding_ready,
    input  wire logic        rx_break_seen,
    input  wire logic        rx_transfer_end,
    input  wire logic        tx_transfer_end,
    input  wire logic        overrun_error,
    input  wire logic        framing_error,
    input  wire logic        rx_timeout,
    input  wire logic        tx_fully_idle,
    input  wire logic        tx_buffer_drained,
    input  wire logic        rx_buffer_full,
    input  wire logic        neg_ack_seen,
    input  wire logic        ring_ind_change,
    input  wire logic        set_ready_change,
    input  wire logic        carrier_detect_change,
    input  wire logic        clear_to_send_change,
    // Received character result.
    input  wire logic        rx_char_done,
    input  wire logic        parity_error,
    // Receive line.
    input  wire logic        rx_line,
    output logic             rx_filtered,
    // Smart-card line acknowledge request and interrupt.
    output logic             neg_ack_send,
    output logic             irq
);
    import uim_pkg::*;

    // Register state and the status value for the next edge.
    logic [31:0] mode_r;
    logic [31:0] mask_r;
    logic [31:0] status_r;
    logic [31:0] status_nxt;
    logic [31:0] events;

    // Successive parity error count and retry-limit pulse.
    logic [2:0]  iter_cnt_r;
    logic        iter_flag_r;

    // Sixteenth-bit sampling of the receive line.
    logic [7:0]  div_cnt_r;
    logic        sample_en;
    logic [2:0]  samples_r;

    // Decoded write strobes.
    logic        wr_mode;
    logic        wr_en_set;
    logic        wr_dis_clr;
    logic        wr_status;

    // Mode fields and acknowledge policy terms.
    logic        inhibit_neg_ack;
    logic        limit_successive_neg_ack;
    logic        in_t0;
    logic [2:0]  max_iter;
    logic        limiting;
    logic        par_evt;
    logic        at_limit;
    logic        filter_on;

    // Two-of-three vote, used by the filter and by its check.
    function automatic logic uim_major(input logic [2:0] s);
        uim_major = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : uim_major

    // Write decode; each strobe hits one register only.
    always_comb begin
        wr_mode    = 1'b0;
        wr_en_set  = 1'b0;
        wr_dis_clr = 1'b0;
        wr_status  = 1'b0;
        if (reg_wr && reg_addr == UIM_OFS_MODE) begin
            wr_mode = 1'b1;
        end else if (reg_wr && reg_addr == UIM_OFS_EN_SET) begin
            wr_en_set = 1'b1;
        end else if (reg_wr && reg_addr == UIM_OFS_DIS_CLR) begin
            wr_dis_clr = 1'b1;
        end else if (reg_wr && reg_addr == UIM_OFS_STATUS) begin
            wr_status = 1'b1;
        end
    end

    // Mode settings used by the acknowledge policy and the filter.
    assign inhibit_neg_ack          = mode_r[UIM_F_INHIBIT_NACK];
    assign limit_successive_neg_ack = mode_r[UIM_F_LIMIT_NACK];
    assign filter_on                = mode_r[UIM_F_FILTER];
    assign max_iter                 = mode_r[UIM_F_MAX_ITER_MSB:UIM_F_MAX_ITER_LSB];
    assign in_t0    = mode_r[UIM_F_MODE_MSB:UIM_F_MODE_LSB] == UIM_MODE_ISO_T0; // R05
    assign limiting = limit_successive_neg_ack && in_t0; // R05
    assign par_evt  = rx_char_done && parity_error;
    assign at_limit = iter_cnt_r >= max_iter; // R04

    // Mode register; unimplemented bits stay zero.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= UIM_MODE_RESET;
        end else if (wr_mode) begin
            mode_r <= reg_wdata & UIM_MODE_BITS;
        end
    end

    // Mask: set-only and clear-only ports, unused bits never stored.
    // The set and clear ports keep nothing of their own; only the mask is stored.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= 32'h0000_0000;
        end else if (wr_en_set) begin
            mask_r <= mask_r | (reg_wdata & UIM_SRC_BITS); // R08 R14
        end else if (wr_dis_clr) begin
            mask_r <= mask_r & ~(reg_wdata & UIM_SRC_BITS); // R09 R14
        end
    end

    // Counter of successive parity errors; a clean character restarts it.
    // Clearing the retry-limit status bit also restarts it, so software can retry.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            iter_cnt_r <= 3'h0;
        end else if (rx_char_done && !parity_error) begin
            iter_cnt_r <= 3'h0;
        end else if (par_evt && limiting && !at_limit) begin
            iter_cnt_r <= iter_cnt_r + 3'h1; // R03
        end else if (wr_status && reg_wdata[UIM_B_RETRY_LIMIT]) begin
            iter_cnt_r <= 3'h0;
        end
    end

    // Acknowledge request, one cycle after the faulty character.
    // The retry flag is only a pulse; the sticky status bit holds it for software.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            neg_ack_send <= 1'b0;
            iter_flag_r  <= 1'b0;
        end else begin
            neg_ack_send <= par_evt && !inhibit_neg_ack && // R01
                            (!limiting || !at_limit); // R02 R03 R04
            iter_flag_r  <= par_evt && limiting && at_limit; // R04
        end
    end

    // Event vector in the shared bit layout.
    always_comb begin
        events = 32'h0000_0000;
        events[UIM_B_RX_CHAR_READY]      = rx_char_ready; // R11
        events[UIM_B_TX_HOLDING_READY]   = tx_holding_ready;
        events[UIM_B_RX_BREAK_SEEN]      = rx_break_seen;
        events[UIM_B_RX_TRANSFER_END]    = rx_transfer_end;
        events[UIM_B_TX_TRANSFER_END]    = tx_transfer_end;
        events[UIM_B_OVERRUN_ERROR]      = overrun_error;
        events[UIM_B_FRAMING_ERROR]      = framing_error;
        events[UIM_B_PARITY_ERROR]       = par_evt;
        events[UIM_B_RX_TIMEOUT]         = rx_timeout; // R12
        events[UIM_B_TX_FULLY_IDLE]      = tx_fully_idle;
        events[UIM_B_RETRY_LIMIT]        = iter_flag_r;
        events[UIM_B_TX_BUFFER_DRAINED]  = tx_buffer_drained;
        events[UIM_B_RX_BUFFER_FULL]     = rx_buffer_full;
        events[UIM_B_NEG_ACK]            = neg_ack_seen;
        events[UIM_B_RING_IND_CHANGE]    = ring_ind_change; // R13
        events[UIM_B_SET_READY_CHANGE]   = set_ready_change;
        events[UIM_B_CARRIER_DET_CHANGE] = carrier_detect_change;
        events[UIM_B_CLEAR_TO_SEND_CHG]  = clear_to_send_change;
    end

    // Sticky status; a new event beats a clear in the same cycle.
    always_comb begin
        status_nxt = status_r;
        if (wr_status) begin
            status_nxt = status_nxt & ~reg_wdata;
        end
        status_nxt = (status_nxt | events) & UIM_SRC_BITS;
    end

    // Status register; bits outside the source set never stick.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= 32'h0000_0000;
        end else begin
            status_r <= status_nxt;
        end
    end

    // Mask value after this cycle's write, for the interrupt term.
    function automatic logic [31:0] mask_nxt_view();
        mask_nxt_view = mask_r;
        if (wr_en_set) begin
            mask_nxt_view = mask_r | (reg_wdata & UIM_SRC_BITS);
        end else if (wr_dis_clr) begin
            mask_nxt_view = mask_r & ~(reg_wdata & UIM_SRC_BITS);
        end
    endfunction : mask_nxt_view

    // Interrupt from the next status, so it follows the register with no lag.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_nxt & mask_nxt_view()); // R15
        end
    end

    // Read data one cycle after the strobe; write-only and unmapped read zero.
    // Zero between reads keeps a stale word from looking like a fresh answer.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd && reg_addr == UIM_OFS_MODE) begin
            reg_rdata <= mode_r;
        end else if (reg_rd && reg_addr == UIM_OFS_MASK) begin
            reg_rdata <= mask_r & UIM_SRC_BITS; // R10 R14
        end else if (reg_rd && reg_addr == UIM_OFS_STATUS) begin
            reg_rdata <= status_r;
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

    // Sixteenth-bit sample enable from a free divider.
    // The divider does not follow the baud generator; it is a fixed rate.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_r <= 8'h00;
        end else if (div_cnt_r == UIM_SAMPLE_LAST) begin
            div_cnt_r <= 8'h00;
        end else begin
            div_cnt_r <= div_cnt_r + 8'h01;
        end
    end

    // One-cycle enable at the end of each divider period.
    assign sample_en = div_cnt_r == UIM_SAMPLE_LAST;

    // Three-sample window; idle line level is high.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            samples_r <= 3'h7;
        end else if (sample_en) begin
            samples_r <= {samples_r[1:0], rx_line}; // R07
        end
    end

    // Filtered or direct receive line, registered either way.
    // The vote delays each line edge by up to two sample periods.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_filtered <= 1'b1;
        end else if (filter_on) begin
            rx_filtered <= uim_major(samples_r); // R07
        end else begin
            rx_filtered <= rx_line; // R06
        end
    end

    // Checks.
    // Properties rest while rst_n is low, so nothing is judged during reset.
    sequence bad_char_s;
        rx_char_done && parity_error;
    endsequence

    inhibit_no_nack_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R01
        $past(inhibit_neg_ack) |-> !neg_ack_send)
        else $error("Negative acknowledge driven while inhibited.");

    plain_nack_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R02
        (bad_char_s and !inhibit_neg_ack and !limiting) |=> neg_ack_send)
        else $error("Parity error without negative acknowledge.");

    count_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R03
        (bad_char_s and limiting and !at_limit)
        |=> iter_cnt_r == $past(iter_cnt_r) + 3'h1)
        else $error("Successive error count did not step.");

    limit_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R04
        (bad_char_s and limiting and at_limit)
        |=> !neg_ack_send ##1 status_r[UIM_B_RETRY_LIMIT])
        else $error("Retry limit did not stop acknowledges or raise flag.");

    t0_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R05
        !in_t0 |=> iter_cnt_r == $past(iter_cnt_r) || iter_cnt_r == 3'h0)
        else $error("Error count moved outside T=0 mode.");

    filter_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R06
        !filter_on |=> rx_filtered == $past(rx_line))
        else $error("Unfiltered line does not follow input.");

    filter_vote_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R07
        filter_on |=> rx_filtered == uim_major($past(samples_r)))
        else $error("Filtered line is not the majority.");

    en_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R08
        wr_en_set |=> mask_r == ($past(mask_r) | ($past(reg_wdata) & UIM_SRC_BITS)))
        else $error("Enable write did not set mask bits.");

    dis_clr_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R09
        wr_dis_clr |=> mask_r == ($past(mask_r) & ~$past(reg_wdata)))
        else $error("Disable write did not clear mask bits.");

    mask_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
        (reg_rd && reg_addr == UIM_OFS_MASK && !reg_wr) |=> reg_rdata == $past(mask_r))
        else $error("Mask read differs from mask.");

    unused_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R14
        (mask_r & ~UIM_SRC_BITS) == 32'h0000_0000
        && (status_r & ~UIM_SRC_BITS) == 32'h0000_0000)
        else $error("Unused bit became set.");

    irq_level_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
        ##1 irq == |(status_r & mask_r))
        else $error("Interrupt does not match status and mask.");

    // Reads answer once; the port must fall back to zero right after.
    rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("Read data present without a read.");

    // Without a port write the mask must not move, a write to the mask address included.
    mask_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R08
        (!wr_en_set && !wr_dis_clr) |=> mask_r == $past(mask_r))
        else $error("Mask changed without a port write.");

    // A faulty character lands in the parity error bit.
    par_status_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
        bad_char_s |=> status_r[UIM_B_PARITY_ERROR])
        else $error("Parity error bit not set.");

    // The card's own negative acknowledge lands in its status bit.
    nack_status_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R12
        neg_ack_seen |=> status_r[UIM_B_NEG_ACK])
        else $error("Negative acknowledge bit not set.");

    // Clear to send changes land in the top implemented bit.
    cts_status_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R13
        clear_to_send_change |=> status_r[UIM_B_CLEAR_TO_SEND_CHG])
        else $error("Clear to send change bit not set.");

    // Each sample enable shifts the line into the window.
    sample_shift_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R07
        sample_en |=> samples_r == {$past(samples_r[1:0]), $past(rx_line)})
        else $error("Sample window did not shift.");

endmodule : uim_top

// file: verif/uim_card_model.sv
// Behavioural card or serial peer that feeds characters and the receive line.
`timescale 1ns/1ps
module uim_card_model (
    // Clock.
    input  wire logic sys_clk,
    // Character results and line toward the block.
    output logic      rx_char_done,
    output logic      parity_error,
    output logic      rx_line,
    // Acknowledge requests from the block.
    input  wire logic neg_ack_send
);
    int nack_cnt = 0;

    // The line idles high; the qualifier starts low.
    initial begin
        rx_char_done = 1'b0;
        parity_error = 1'b0;
        rx_line      = 1'b1;
    end

    // Count every acknowledge request the block puts on the card line.
    always @(posedge sys_clk) begin
        if (neg_ack_send === 1'b1) begin
            nack_cnt++;
        end
    end

    // One character; the qualifier drops afterwards and the error flag is inverted so nothing stale looks valid.
    task automatic send_char(input logic err);
        @(posedge sys_clk);
        rx_char_done <= 1'b1;
        parity_error <= err;
        @(posedge sys_clk);
        rx_char_done <= 1'b0;
        parity_error <= ~err;
        repeat (4) @(posedge sys_clk);
    endtask : send_char

    // Hold the line at a level for a number of clocks.
    task automatic drive_line(input logic lvl, input int n);
        @(posedge sys_clk);
        rx_line <= lvl;
        repeat (n) @(posedge sys_clk);
    endtask : drive_line
endmodule : uim_card_model

// file: verif/usart_irq_mask_and_retry_nack_tb.sv
// Self-checking bench for the interrupt mask, acknowledge policy and line filter.
`timescale 1ns/1ps
module usart_irq_mask_and_retry_nack_tb;
    import uim_pkg::*;
    logic        sys_clk   = 1'b0;
    logic        rst_n     = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [31:0] reg_rdata;
    logic [19:0] ev        = 20'h0;
    logic        rx_char_done, parity_error, rx_line, rx_filtered, neg_ack_send, irq;
    int          miscompares = 0;
    int          checks      = 0;
    int          cyc         = 0;

    uim_top uim_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .rx_char_ready(ev[0]), .tx_holding_ready(ev[1]), .rx_break_seen(ev[2]),
        .rx_transfer_end(ev[3]), .tx_transfer_end(ev[4]), .overrun_error(ev[5]),
        .framing_error(ev[6]), .rx_timeout(ev[8]), .tx_fully_idle(ev[9]),
        .tx_buffer_drained(ev[11]), .rx_buffer_full(ev[12]), .neg_ack_seen(ev[13]),
        .ring_ind_change(ev[16]), .set_ready_change(ev[17]),
        .carrier_detect_change(ev[18]), .clear_to_send_change(ev[19]),
        .rx_char_done(rx_char_done), .parity_error(parity_error), .rx_line(rx_line),
        .rx_filtered(rx_filtered), .neg_ack_send(neg_ack_send), .irq(irq));

    uim_card_model uim_card_model_inst (.sys_clk(sys_clk), .rx_char_done(rx_char_done),
        .parity_error(parity_error), .rx_line(rx_line), .neg_ack_send(neg_ack_send));

    // Clock at 100 MHz.
    always #5 sys_clk = ~sys_clk;

    // Cut a hang short; the whole run needs far fewer cycles than this.
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] dt);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= dt;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] dt);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 dt = reg_rdata;
    endtask : rd

    // Mode word from its fields.
    function automatic logic [31:0] mw(logic [3:0] md, logic inh, logic lim, logic [2:0] mx,
                                       logic flt);
        mw = {28'h0, md} | (32'(inh) << UIM_F_INHIBIT_NACK) | (32'(lim) << UIM_F_LIMIT_NACK)
           | (32'(mx) << UIM_F_MAX_ITER_LSB) | (32'(flt) << UIM_F_FILTER);
    endfunction : mw

    // Set, clear and readback of the mask, including the unused bits.
    task automatic t_mask();
        logic [31:0] d;
        rd(UIM_OFS_MASK, d);
        chk("mask reset", 32'h0, d);
        wr(UIM_OFS_EN_SET, 32'hffff_ffff);
        rd(UIM_OFS_MASK, d);
        chk("mask all set", 32'h000f_3fff, d);
        wr(UIM_OFS_DIS_CLR, 32'hfff0_0f0f);
        rd(UIM_OFS_MASK, d);
        chk("mask cleared", 32'h000f_30f0, d);
        wr(UIM_OFS_EN_SET, 32'h0000_0000);
        rd(UIM_OFS_MASK, d);
        chk("mask kept", 32'h000f_30f0, d);
        wr(UIM_OFS_MASK, 32'h0);
        wr(UIM_OFS_EN_SET, 32'h0000_0f0f);
        rd(UIM_OFS_MASK, d);
        chk("mask refilled", 32'h000f_3fff, d);
    endtask : t_mask

    // Each event source except parity error and retry limit reaches its own bit and drives the interrupt while enabled.
    task automatic t_events();
        logic [31:0] d;
        wr(UIM_OFS_STATUS, 32'hffff_ffff);
        for (int b = 0; b < 20; b++) begin
            if (UIM_SRC_BITS[b] && b != 7 && b != 10) begin
                @(posedge sys_clk) ev[b] <= 1'b1;
                @(posedge sys_clk) ev[b] <= 1'b0;
                #1 chk("irq raised", 32'h1, {31'h0, irq});
                rd(UIM_OFS_STATUS, d);
                chk("event bit", 32'h1 << b, d);
                wr(UIM_OFS_STATUS, 32'h1 << b);
                chk("irq cleared", 32'h0, {31'h0, irq});
            end
        end
        wr(UIM_OFS_DIS_CLR, 32'h0000_0020);
        @(posedge sys_clk) ev[5] <= 1'b1;
        @(posedge sys_clk) ev[5] <= 1'b0;
        #1 chk("irq masked", 32'h0, {31'h0, irq});
        rd(UIM_OFS_MASK, d);
        chk("mask view", 32'h000f_3fdf, d);
        wr(UIM_OFS_EN_SET, 32'h0000_0020);
        chk("irq unmasked", 32'h1, {31'h0, irq});
        wr(UIM_OFS_STATUS, 32'h0000_0020);
    endtask : t_events

    // A run of error characters under one mode word, counting acknowledges.
    task automatic nack_run(input string nm, input logic [31:0] m, input int n,
                            input int exp);
        int base;
        wr(UIM_OFS_MODE, m);
        wr(UIM_OFS_STATUS, 32'hffff_ffff);
        base = uim_card_model_inst.nack_cnt;
        repeat (n) uim_card_model_inst.send_char(1'b1);
        uim_card_model_inst.send_char(1'b0);
        chk(nm, 32'(exp), 32'(uim_card_model_inst.nack_cnt - base));
    endtask : nack_run

    // Acknowledge policy across inhibit, limiting, retry count and mode.
    task automatic t_nack();
        logic [31:0] d;
        nack_run("nack plain", mw(4'h0, 1'b0, 1'b0, 3'h0, 1'b0), 3, 3);
        nack_run("nack inhibit", mw(UIM_MODE_ISO_T0, 1'b1, 1'b0, 3'h2, 1'b0), 3, 0);
        nack_run("nack limit", mw(UIM_MODE_ISO_T0, 1'b0, 1'b1, 3'h2, 1'b0), 3, 2);
        rd(UIM_OFS_STATUS, d);
        chk("retry flag", 32'h0000_0480, d & 32'h0000_0480);
        chk("retry irq", 32'h1, {31'h0, irq});
        rd(UIM_OFS_MODE, d);
        chk("mode view", mw(UIM_MODE_ISO_T0, 1'b0, 1'b1, 3'h2, 1'b0), d);
        nack_run("nack max zero", mw(UIM_MODE_ISO_T0, 1'b0, 1'b1, 3'h0, 1'b0), 1, 0);
        nack_run("nack non t0", mw(4'h0, 1'b0, 1'b1, 3'h2, 1'b0), 3, 3);
    endtask : t_nack

    // Line passes straight when off; a one-sample glitch is voted out when on.
    task automatic t_filter();
        int lows = 0;
        wr(UIM_OFS_MODE, mw(4'h0, 1'b0, 1'b0, 3'h0, 1'b0));
        uim_card_model_inst.drive_line(1'b0, 2);
        #1 chk("unfiltered low", 32'h0, {31'h0, rx_filtered});
        uim_card_model_inst.drive_line(1'b1, 64);
        wr(UIM_OFS_MODE, mw(4'h0, 1'b0, 1'b0, 3'h0, 1'b1));
        @(posedge sys_clk) uim_card_model_inst.rx_line <= 1'b0;
        repeat (16) @(posedge sys_clk) lows += (rx_filtered === 1'b0);
        uim_card_model_inst.rx_line <= 1'b1;
        repeat (48) @(posedge sys_clk) lows += (rx_filtered === 1'b0);
        chk("glitch lows", 32'h0, 32'(lows));
        uim_card_model_inst.drive_line(1'b0, 64);
        chk("filtered low", 32'h0, {31'h0, rx_filtered});
    endtask : t_filter

    task automatic wrap_up();
        if (miscompares == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // Main sequence.
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        #1 chk("irq at reset", 32'h0, {31'h0, irq});
        chk("filter at reset", 32'h1, {31'h0, rx_filtered});
        t_mask();
        t_events();
        t_nack();
        t_filter();
        wrap_up();
    end
endmodule : usart_irq_mask_and_retry_nack_tb
